// [design/count_tick_gen.sv]
`timescale 1ns/1ns
// ********************************************************************
// count clock prescaler: one-cycle tick every 4 or 64 system clocks
// ********************************************************************
module count_tick_gen
    import frt_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    // selection
    input wire logic [1:0] clk_sel_in,
    // tick
    output logic tick_out
);
    logic [PRESCALE_W-1:0] pre_q;
    logic [PRESCALE_W-1:0] pre_d;
    wire logic [PRESCALE_W-1:0] div4_last;
    wire logic [PRESCALE_W-1:0] div64_last;
    wire logic at_end;

    assign div4_last = PRESCALE_W'(DIV4_CYCLES - 1);
    assign div64_last = PRESCALE_W'(DIV64_CYCLES - 1);
    // prohibited codes stop the count clock rather than guess a rate
    assign at_end = (clk_sel_in == CLK_DIV4) ? (pre_q[1:0] == div4_last[1:0])
                  : (clk_sel_in == CLK_DIV64) ? (pre_q == div64_last)
                  : 1'b0;
    assign pre_d = pre_q + PRESCALE_W'(1);

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pre_q <= '0;
            tick_out <= 1'b0;
        end else if (ce_in) begin
            pre_q <= pre_d;
            tick_out <= at_end;
        end
    end
endmodule : count_tick_gen

// [design/free_running_timer_compare_capture.sv]
`timescale 1ns/1ns
// How it works
// - counter increments on each count tick; reset clears it to zero
// - counter equal to compare value raises the match interrupt
// - compare register takes any 16-bit value; reset loads all ones
// - capture register has no reset value; logic never relies on it
// - low byte read freezes a read buffer until the high byte read
// - reset clears the whole mode control register
// - mode register: level, overflow, edge, invert, clock, enable
// - overflow flag sets on wrap; cleared by reset or writing zero
// - edge field: off, rising, falling, both
// - selected edge copies counter into capture register, held
// - compare rewrite may cause an immediate match interrupt
// - counter runs through stabilization time; value then undefined
// - match can drive the timer output pin per mode register
// - invert and enable set: each match toggles the output
// - clock select 00 divides by 4, 01 by 64, others stop
// - enable 0 leaves pin as port; 1 puts timer output on it
// - output level bit is read-only; writes ignored
module free_running_timer_compare_capture
    import frt_pkg::*;
(
    // clock, reset, enable
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    // memory access port, byte wide
    input wire logic [15:0] addr_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [7:0] wdata_in,
    output logic [7:0] rdata_out,
    // pins
    input wire logic capture_trigger_pin_in,
    input wire logic port_latch_in,
    output logic timer_out_pin_out,
    // interrupt
    output logic match_irq_out
);
    // ****************************************************************
    // state
    // ****************************************************************
    logic [15:0] free_counter_q;
    logic [15:0] compare_value_q;
    logic [15:0] captured_count_q;
    logic [15:0] read_buf_q;
    logic hold_q;
    logic trig_q;
    logic [7:0] mode_q;
    logic tick;

    wire logic [1:0] edge_sel;
    wire logic [1:0] clk_sel;
    wire logic out_en;
    wire logic inv_en;
    wire logic level;
    wire logic rise;
    wire logic fall;
    wire logic cap_hit;
    wire logic match;
    wire logic wrap;
    wire logic wr_mode;
    wire logic rd_lo;
    wire logic rd_hi;
    wire logic [15:0] cnt_view;
    logic [7:0] rdata_d;

    assign edge_sel = mode_q[EDGE_HI_BIT:EDGE_LO_BIT];
    assign clk_sel = mode_q[CLK_HI_BIT:CLK_LO_BIT];
    assign out_en = mode_q[OUT_EN_BIT];
    assign inv_en = mode_q[INV_BIT];
    assign level = mode_q[OUT_LEVEL_BIT];

    count_tick_gen u_tick (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .clk_sel_in(clk_sel),
        .tick_out(tick)
    );

    // ****************************************************************
    // decode
    // ****************************************************************
    // a match is judged once per count tick so it fires a single pulse
    assign match = tick && (free_counter_q == compare_value_q);
    assign wrap = tick && (free_counter_q == 16'hFFFF);
    assign rise = capture_trigger_pin_in && !trig_q;
    assign fall = !capture_trigger_pin_in && trig_q;
    assign cap_hit = ((edge_sel == EDGE_RISE) && rise)
                  || ((edge_sel == EDGE_FALL) && fall)
                  || ((edge_sel == EDGE_BOTH) && (rise || fall));
    assign wr_mode = wr_in && (addr_in == MODE_ADDR);
    assign rd_lo = rd_in && (addr_in == CNT_LO_ADDR);
    assign rd_hi = rd_in && (addr_in == CNT_HI_ADDR);
    // live count passes through until a low-byte read freezes it
    assign cnt_view = hold_q ? read_buf_q : free_counter_q;

    always_comb begin
        case (addr_in)
            MODE_ADDR: rdata_d = mode_q;
            CMP_LO_ADDR: rdata_d = compare_value_q[7:0];
            CMP_HI_ADDR: rdata_d = compare_value_q[15:8];
            CNT_LO_ADDR: rdata_d = free_counter_q[7:0];
            CNT_HI_ADDR: rdata_d = cnt_view[15:8];
            CAP_LO_ADDR: rdata_d = captured_count_q[7:0];
            CAP_HI_ADDR: rdata_d = captured_count_q[15:8];
            default: rdata_d = 8'h00;
        endcase
    end

    // ****************************************************************
    // counter, compare, read buffer
    // ****************************************************************
    // the counter has no stop-release handling: it just keeps running
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            free_counter_q <= CNT_RESET;
            compare_value_q <= CMP_RESET;
            hold_q <= 1'b0;
            read_buf_q <= CNT_RESET;
            trig_q <= 1'b0;
        end else if (ce_in) begin
            if (tick) begin
                free_counter_q <= free_counter_q + 16'h0001;
            end
            if (wr_in && addr_in == CMP_LO_ADDR) begin
                compare_value_q[7:0] <= wdata_in;
            end
            if (wr_in && addr_in == CMP_HI_ADDR) begin
                compare_value_q[15:8] <= wdata_in;
            end
            if (rd_lo) begin
                read_buf_q <= free_counter_q;
                hold_q <= 1'b1;
            end else if (rd_hi) begin
                hold_q <= 1'b0;
            end
            trig_q <= capture_trigger_pin_in;
        end
    end

    // capture register deliberately has no reset term
    always_ff @(posedge clk_in) begin
        if (ce_in && cap_hit) begin
            captured_count_q <= free_counter_q;
        end
    end

    // ****************************************************************
    // mode register, output and interrupt
    // ****************************************************************
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            mode_q <= MODE_RESET;
        end else if (ce_in) begin
            if (wr_mode) begin
                mode_q[5:0] <= wdata_in[5:0];
            end
            // a wrap in the same cycle as a zero write keeps the flag
            if (wrap) begin
                mode_q[OVF_BIT] <= 1'b1;
            end else if (wr_mode && !wdata_in[OVF_BIT]) begin
                mode_q[OVF_BIT] <= 1'b0;
            end
            // level starts low while output disabled; only matches change it
            if (!out_en) begin
                mode_q[OUT_LEVEL_BIT] <= 1'b0;
            end else if (match && inv_en) begin
                mode_q[OUT_LEVEL_BIT] <= !level;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            match_irq_out <= 1'b0;
            timer_out_pin_out <= 1'b0;
            rdata_out <= 8'h00;
        end else if (ce_in) begin
            match_irq_out <= match;
            timer_out_pin_out <= out_en ? level : port_latch_in;
            rdata_out <= rdata_d;
        end
    end
endmodule : free_running_timer_compare_capture

// [design/frt_pkg.sv]
package frt_pkg;
    // ****************************************************************
    // register map and field layout
    // ****************************************************************
    localparam logic [15:0] MODE_ADDR = 16'hFF48;
    // compare and counter have no printed address; values are arbitrary
    localparam logic [15:0] CMP_LO_ADDR = 16'hFF40;
    localparam logic [15:0] CMP_HI_ADDR = 16'hFF41;
    localparam logic [15:0] CNT_LO_ADDR = 16'hFF42;
    localparam logic [15:0] CNT_HI_ADDR = 16'hFF43;
    localparam logic [15:0] CAP_LO_ADDR = 16'hFF44;
    localparam logic [15:0] CAP_HI_ADDR = 16'hFF45;
    localparam int OUT_LEVEL_BIT = 7;
    localparam int OVF_BIT = 6;
    localparam int EDGE_HI_BIT = 5;
    localparam int EDGE_LO_BIT = 4;
    localparam int INV_BIT = 3;
    localparam int CLK_HI_BIT = 2;
    localparam int CLK_LO_BIT = 1;
    localparam int OUT_EN_BIT = 0;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [15:0] CMP_RESET = 16'hFFFF;
    localparam logic [15:0] CNT_RESET = 16'h0000;
    // ****************************************************************
    // capture edge codes and count clock division
    // ****************************************************************
    localparam logic [1:0] EDGE_NONE = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;
    localparam logic [1:0] CLK_DIV4 = 2'h0;
    localparam logic [1:0] CLK_DIV64 = 2'h1;
    localparam int DIV4_CYCLES = 4;
    localparam int DIV64_CYCLES = 64;
    localparam int PRESCALE_W = 6;
endpackage : frt_pkg

// [testbench/free_running_timer_compare_capture_test.sv]
`timescale 1ns/1ns
module free_running_timer_compare_capture_test
    import frt_pkg::*;
;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [15:0] addr_in = 16'h0000;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic [7:0] wdata_in = 8'h00;
    logic port_latch_in = 1'b0;
    logic [7:0] rdata_out;
    logic capture_trigger_pin_in;
    logic timer_out_pin_out;
    logic match_irq_out;
    int n_errors = 0;
    int n_checks = 0;
    logic [15:0] a;
    logic [15:0] b;
    logic [15:0] d;
    logic seen;
    always #10 clk_in = ~clk_in;
    free_running_timer_compare_capture
        free_running_timer_compare_capture_inst (.clk_in, .rst_in,
        .ce_in(1'b1), .addr_in, .wr_in, .rd_in, .wdata_in, .rdata_out,
        .capture_trigger_pin_in, .port_latch_in, .timer_out_pin_out,
        .match_irq_out);
    trig_source trig_source_inst (.clk_in, .trig_out(capture_trigger_pin_in));
    task automatic chk(input string nm, input logic [15:0] e, g);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic acc(input logic [15:0] ad, input logic w, input logic
        [7:0] v, output logic [7:0] q);
        addr_in = ad;
        wdata_in = v;
        wr_in = w;
        rd_in = !w;
        @(posedge clk_in);
        #1 wr_in = 1'b0;
        rd_in = 1'b0;
        q = rdata_out;
        @(posedge clk_in);
        #1;
    endtask : acc
    task automatic rd16(input logic [15:0] ad, output logic [15:0] v);
        acc(ad, 1'b0, 8'h00, v[7:0]);
        acc(ad + 16'h0001, 1'b0, 8'h00, v[15:8]);
    endtask : rd16
    task automatic summarize();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : summarize
    initial begin
        repeat (4) @(posedge clk_in);
        #1 rst_in = 1'b0;
        rd16(CNT_LO_ADDR, a);
        chk("cnt_hi", 16'h0000, {8'h00, a[15:8]});
        rd16(CMP_LO_ADDR, a);
        chk("cmp", CMP_RESET, a);
        acc(MODE_ADDR, 1'b0, 8'h00, a[7:0]);
        chk("mode", {8'h00, MODE_RESET}, {8'h00, a[7:0]});
        acc(MODE_ADDR, 1'b1, 8'h81, a[7:0]);
        acc(MODE_ADDR, 1'b0, 8'h00, a[7:0]);
        chk("mode_ro", 16'h0001, {8'h00, a[7:0]});
        port_latch_in = 1'b1;
        // code 10 is a prohibited selection, which holds the count
        for (int s = 0; s < 3; s++) begin
            acc(MODE_ADDR, 1'b1, 8'(s << 1), a[7:0]);
            rd16(CNT_LO_ADDR, a);
            repeat (s == 1 ? 636 : 60) @(posedge clk_in);
            rd16(CNT_LO_ADDR, b);
            d = b - a - (s == 0 ? 16'h0010 : s == 1 ? 16'h000A : 16'h0000);
            chk("rate", 16'h0000, (s < 2 && d + 16'h0001 <= 16'h0002) ?
                16'h0000 : d);
        end
        port_latch_in = 1'b0;
        a = b + 16'h0028;
        // inversion is off while the compare value is rewritten
        acc(CMP_HI_ADDR, 1'b1, a[15:8], d[7:0]);
        acc(CMP_LO_ADDR, 1'b1, a[7:0], d[7:0]);
        acc(MODE_ADDR, 1'b1, 8'h09, d[7:0]);
        seen = 1'b0;
        for (int i = 0; i < 400 && !seen; i++) begin
            @(posedge clk_in);
            #1 seen = match_irq_out;
        end
        chk("irq", 16'h0001, {15'h0000, seen});
        repeat (2) @(posedge clk_in);
        #1 chk("pin", 16'h0001, {15'h0000, timer_out_pin_out});
        acc(MODE_ADDR, 1'b0, 8'h00, b[7:0]);
        chk("mode_run", 16'h0089, {8'h00, b[7:0]});
        rd16(CNT_LO_ADDR, b);
        d = b - a;
        chk("cnt_run", 16'h0000, d < 16'h0004 ? 16'h0000 : d);
        for (int c = 0; c < 4; c++) begin
            acc(MODE_ADDR, 1'b1, 8'(c << 4), d[7:0]);
            rd16(CAP_LO_ADDR, a);
            trig_source_inst.move(1'b1);
            rd16(CAP_LO_ADDR, b);
            chk("cap_rise", {15'h0000, c[0]}, {15'h0000, b !== a});
            trig_source_inst.move(1'b0);
            rd16(CAP_LO_ADDR, a);
            chk("cap_fall", {15'h0000, c[1]}, {15'h0000, a !== b});
        end
        summarize();
    end
    initial begin
        #400000;
        n_errors++;
        summarize();
    end
endmodule : free_running_timer_compare_capture_test

// [testbench/frt_sva.sv]
`timescale 1ns/1ns
// ******
// port checker
// ******
module frt_sva
    import frt_pkg::*;
(
    // clock and bus
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic [15:0] addr_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [7:0] wdata_in,
    input wire logic [7:0] rdata_out,
    // pins
    input wire logic capture_trigger_pin_in,
    input wire logic port_latch_in,
    input wire logic timer_out_pin_out,
    input wire logic match_irq_out
);
    // invert and enable bits mirrored from bus writes
    logic [1:0] ctl_q;
    wire mode_wr = ce_in && wr_in && addr_in == MODE_ADDR;
    wire on_inv = ctl_q == 2'h3;
    wire on_plain = ctl_q == 2'h1;
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ctl_q <= 2'h0;
        end else if (mode_wr) begin
            ctl_q <= {wdata_in[INV_BIT], wdata_in[OUT_EN_BIT]};
        end
    end
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);
    property p_rst; disable iff (1'b0) rst_in |=> !match_irq_out
        && !timer_out_pin_out && rdata_out == 8'h00; endproperty
    a_rst: assert property (p_rst) else $error("reset state");
    property p_pulse; $rose(match_irq_out) |=> $fell(match_irq_out);
    endproperty
    a_pulse: assert property (p_pulse) else $error("irq width");
    property p_gap; match_irq_out |=> !match_irq_out [*3]; endproperty
    a_gap: assert property (p_gap) else $error("irq gap");
    property p_unmap; ce_in && addr_in == 16'h0000 |=> rdata_out == 8'h00;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped");
    property p_port; !ctl_q[0] ##1 !ctl_q[0] && $stable(port_latch_in)
        |-> timer_out_pin_out == port_latch_in; endproperty
    a_port: assert property (p_port) else $error("port mode");
    property p_steady; on_plain [*3] |-> $stable(timer_out_pin_out);
    endproperty
    a_steady: assert property (p_steady) else $error("toggle");
    property p_toggle; match_irq_out && on_inv && $past(on_inv)
        && $past(on_inv, 2) |=> $changed(timer_out_pin_out); endproperty
    a_toggle: assert property (p_toggle) else $error("no toggle");
    // the level bit clears one cycle after the disabling write lands
    property p_lvl; ce_in && addr_in == MODE_ADDR && !ctl_q[0]
        && !$past(ctl_q[0]) |=> !rdata_out[OUT_LEVEL_BIT]; endproperty
    a_lvl: assert property (p_lvl) else $error("level bit");
endmodule : frt_sva
bind free_running_timer_compare_capture frt_sva frt_sva_inst (.clk_in,
    .rst_in, .ce_in, .addr_in, .wr_in, .rd_in, .wdata_in, .rdata_out,
    .capture_trigger_pin_in, .port_latch_in, .timer_out_pin_out,
    .match_irq_out);

// [testbench/trig_source.sv]
`timescale 1ns/1ns
// ******
// trigger source
// ******
module trig_source (
    // clock
    input wire logic clk_in,
    // pins
    output logic trig_out
);
    initial trig_out = 1'b0;
    // hold after the edge so the capture lands before a read
    task automatic move(input logic v);
        @(posedge clk_in);
        #1 trig_out = v;
        repeat (4) @(posedge clk_in);
        #1;
    endtask : move
endmodule : trig_source
